/* File: core/pgcd_dev.sv */
// Device end: decodes command codes and serves data bytes
`timescale 1ns/1ns
`include "pgcd_regs.svh"
module pgcd_dev
  import pgcd_pkg::*;
#(
  parameter int NUM_ENTRIES = `PGCD_NUM_ENTRIES
)
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  pgcd_if.dev bus,
  input wire logic [7:0] ep_status_i [NUM_ENTRIES],
  input wire logic [7:0] ep_error_i [NUM_ENTRIES],
  input wire logic [15:0] frame_count_i,
  output logic setup_ack_o,
  output logic unlocked_o,
  output logic [15:0] scratch_word_o
);
  typedef struct packed {
    pgcd_phase_t phase;
    pgcd_kind_t kind;
    logic [3:0] ep;
    logic [1:0] cnt;
    logic [7:0] rdata;
    logic [7:0] lo;
    logic [15:0] scratch;
    logic unlocked;
    logic ack;
  } pgcd_dev_st_t;
  pgcd_dev_st_t st_ff;
  pgcd_dev_st_t nxt_st;
  logic [15:0] rd_word;
  logic [NUM_ENTRIES-1:0] ep_hit;
  logic [7:0] stat_term [NUM_ENTRIES];
  logic [7:0] err_term [NUM_ENTRIES];
  logic [7:0] stat_sel;
  logic [7:0] err_sel;
  // ----------------------------------------
  // Endpoint byte select, absent entries zero
  // ----------------------------------------
  for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_entry
    assign ep_hit[g] = (st_ff.ep == 4'(g));
    assign stat_term[g] = ep_hit[g] ? ep_status_i[g] : `PGCD_RST_BYTE;
    assign err_term[g] = ep_hit[g] ? ep_error_i[g] : `PGCD_RST_BYTE;
  end
  always_comb begin
    stat_sel = `PGCD_RST_BYTE;
    err_sel = `PGCD_RST_BYTE;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      stat_sel = stat_sel | stat_term[i];
      err_sel = err_sel | err_term[i];
    end
  end
  // ----------------------------------------
  // Read word selection
  // ----------------------------------------
  always_comb begin
    unique case (st_ff.kind)
      PGCD_K_STAT: rd_word = {`PGCD_RST_BYTE, stat_sel}; // [RULE_01] [RULE_02] [RULE_11]
      PGCD_K_ERR: rd_word = {`PGCD_RST_BYTE, err_sel}; // [RULE_04] [RULE_05] [RULE_06]
      PGCD_K_SCRR: rd_word = st_ff.scratch; // [RULE_08]
      PGCD_K_FRAME: rd_word = frame_count_i; // [RULE_09]
      PGCD_K_ID: rd_word = `PGCD_ID_VALUE; // [RULE_10]
      default: rd_word = `PGCD_RST_WORD;
    endcase
  end
  // ----------------------------------------
  // Command decode and data phase
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    if (bus.cmd_wr) begin // [RULE_12]
      nxt_st.phase = PGCD_IDLE;
      nxt_st.kind = PGCD_K_NONE; // [RULE_13]
      nxt_st.cnt = `PGCD_LEN_NONE;
      nxt_st.ep = bus.wdata[3:0] & 4'(`PGCD_EP_MASK);
      if (bus.wdata >= `PGCD_CMD_STAT_BASE && bus.wdata <= `PGCD_CMD_STAT_LAST) begin
        nxt_st.phase = PGCD_RD; // [RULE_01] [RULE_02] [RULE_11]
        nxt_st.kind = PGCD_K_STAT;
        nxt_st.cnt = `PGCD_LEN_ONE;
      end else if (bus.wdata >= `PGCD_CMD_ERR_BASE && bus.wdata <= `PGCD_CMD_ERR_LAST) begin
        nxt_st.phase = PGCD_RD; // [RULE_04] [RULE_05] [RULE_06]
        nxt_st.kind = PGCD_K_ERR;
        nxt_st.cnt = `PGCD_LEN_ONE;
      end else if (bus.wdata == `PGCD_CMD_ACK_SETUP) begin
        nxt_st.ack = 1'b1; // [RULE_03]
      end else if (bus.wdata == `PGCD_CMD_UNLOCK) begin
        nxt_st.phase = PGCD_WR; // [RULE_07]
        nxt_st.kind = PGCD_K_UNLOCK;
        nxt_st.cnt = `PGCD_LEN_TWO;
      end else if (bus.wdata == `PGCD_CMD_SCR_WR) begin
        nxt_st.phase = PGCD_WR; // [RULE_08]
        nxt_st.kind = PGCD_K_SCRW;
        nxt_st.cnt = `PGCD_LEN_TWO;
      end else if (bus.wdata == `PGCD_CMD_SCR_RD) begin
        nxt_st.phase = PGCD_RD; // [RULE_08]
        nxt_st.kind = PGCD_K_SCRR;
        nxt_st.cnt = `PGCD_LEN_TWO;
      end else if (bus.wdata == `PGCD_CMD_FRAME) begin
        nxt_st.phase = PGCD_RD; // [RULE_09]
        nxt_st.kind = PGCD_K_FRAME;
        nxt_st.cnt = `PGCD_LEN_TWO;
      end else if (bus.wdata == `PGCD_CMD_ID) begin
        nxt_st.phase = PGCD_RD; // [RULE_10]
        nxt_st.kind = PGCD_K_ID;
        nxt_st.cnt = `PGCD_LEN_TWO;
      end
    end else begin
      unique case (st_ff.phase)
        PGCD_IDLE: begin
        end
        PGCD_WR: if (bus.data_wr) begin
          nxt_st.cnt = st_ff.cnt - 2'h1;
          if (st_ff.cnt == `PGCD_LEN_TWO) begin
            nxt_st.lo = bus.wdata;
          end else begin
            nxt_st.phase = PGCD_IDLE;
            if (st_ff.kind == PGCD_K_SCRW) begin
              nxt_st.scratch = {bus.wdata, st_ff.lo}; // [RULE_08]
            end else begin
              nxt_st.unlocked = ({bus.wdata, st_ff.lo} == `PGCD_UNLOCK_KEY); // [RULE_07]
            end
          end
        end
        PGCD_RD: if (bus.data_rd) begin
          nxt_st.cnt = st_ff.cnt - 2'h1;
          nxt_st.rdata = (st_ff.cnt == `PGCD_LEN_TWO || st_ff.kind == PGCD_K_STAT ||
            st_ff.kind == PGCD_K_ERR) ? rd_word[7:0] : rd_word[15:8]; // [RULE_09]
          if (st_ff.cnt == `PGCD_LEN_ONE) begin
            nxt_st.phase = PGCD_IDLE;
          end
        end
        default: nxt_st.phase = PGCD_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // State register and outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end
  assign bus.rdata = st_ff.rdata;
  assign setup_ack_o = st_ff.ack;
  assign unlocked_o = st_ff.unlocked;
  assign scratch_word_o = st_ff.scratch;
endmodule : pgcd_dev

/* File: core/pgcd_host.sv */
// Processor end: issues one command and its data transfers
`timescale 1ns/1ns
`include "pgcd_regs.svh"
module pgcd_host
  import pgcd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  pgcd_if.host bus,
  input wire logic req_i,
  input wire logic [7:0] req_cmd_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic [1:0] req_len_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o
);
  typedef struct packed {
    pgcd_phase_t phase;
    logic [1:0] cnt;
    logic [1:0] got;
    logic [15:0] wbuf;
    logic [15:0] rbuf;
    logic pend;
    logic done;
    logic cmd_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } pgcd_host_st_t;
  pgcd_host_st_t st_ff;
  pgcd_host_st_t nxt_st;
  logic is_write;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign is_write = (req_cmd_i == `PGCD_CMD_UNLOCK) || (req_cmd_i == `PGCD_CMD_SCR_WR); // [RULE_07] [RULE_08]
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cmd_wr = 1'b0;
    nxt_st.data_wr = 1'b0;
    nxt_st.data_rd = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.pend = 1'b0;
    if (st_ff.pend) begin
      nxt_st.rbuf = (st_ff.got == `PGCD_LEN_ONE) ? {`PGCD_RST_BYTE, bus.rdata} : {bus.rdata, st_ff.rbuf[7:0]};
    end
    unique case (st_ff.phase)
      PGCD_IDLE: if (req_i) begin
        nxt_st.cmd_wr = 1'b1; // [RULE_12]
        nxt_st.wdata = req_cmd_i;
        nxt_st.wbuf = req_wdata_i;
        nxt_st.cnt = req_len_i; // [RULE_03] [RULE_09]
        nxt_st.got = `PGCD_LEN_NONE;
        nxt_st.rbuf = `PGCD_RST_WORD;
        nxt_st.phase = is_write ? PGCD_WR : PGCD_RD;
      end
      PGCD_WR: if (st_ff.cnt == `PGCD_LEN_NONE) begin
        nxt_st.phase = PGCD_IDLE;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.data_wr = 1'b1;
        nxt_st.wdata = st_ff.wbuf[7:0];
        nxt_st.wbuf = {`PGCD_RST_BYTE, st_ff.wbuf[15:8]};
        nxt_st.cnt = st_ff.cnt - 2'h1;
      end
      PGCD_RD: if (st_ff.cnt == `PGCD_LEN_NONE) begin
        if (!st_ff.data_rd && !st_ff.pend) begin
          nxt_st.phase = PGCD_IDLE;
          nxt_st.done = 1'b1;
        end
      end else if (!st_ff.data_rd) begin
        nxt_st.data_rd = 1'b1; // [RULE_01] [RULE_10]
        nxt_st.cnt = st_ff.cnt - 2'h1;
      end
      default: nxt_st.phase = PGCD_IDLE;
    endcase
    if (st_ff.data_rd) begin
      nxt_st.pend = 1'b1;
      nxt_st.got = st_ff.got + 2'h1;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end
  assign bus.cmd_wr = st_ff.cmd_wr;
  assign bus.data_wr = st_ff.data_wr;
  assign bus.data_rd = st_ff.data_rd;
  assign bus.wdata = st_ff.wdata;
  assign busy_o = (st_ff.phase != PGCD_IDLE);
  assign done_o = st_ff.done;
  assign rdata_o = st_ff.rbuf;
endmodule : pgcd_host

/* File: core/pgcd_if.sv */
// Command and data port between processor and decoder
`timescale 1ns/1ns
interface pgcd_if;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dev (input cmd_wr, input data_wr, input data_rd, input wdata, output rdata);
  modport host (output cmd_wr, output data_wr, output data_rd, output wdata, input rdata);
endinterface : pgcd_if

/* File: core/pgcd_pkg.sv */
// Types shared by both ends of the command decoder
package pgcd_pkg;
  typedef enum logic [1:0] {PGCD_IDLE, PGCD_WR, PGCD_RD} pgcd_phase_t;
  typedef enum logic [2:0] {PGCD_K_NONE, PGCD_K_STAT, PGCD_K_ERR, PGCD_K_UNLOCK,
    PGCD_K_SCRW, PGCD_K_SCRR, PGCD_K_FRAME, PGCD_K_ID} pgcd_kind_t;
endpackage : pgcd_pkg

/* File: core/pgcd_regs.svh */
// Command codes, byte counts and reset values of the command decoder
// ----------------------------------------
// Functional notes
// ----------------------------------------
// Functional notes
// [RULE_01] D1 reads control IN status, one byte
// [RULE_02] D2-DF read data endpoint 1-14 status
// [RULE_03] F4 acknowledges setup, no data phase
// [RULE_04] A0 reads control OUT error code byte
// [RULE_05] A1 reads control IN error code byte
// [RULE_06] A2-AF read endpoint 1-14 error code
// [RULE_07] B0 unlocks writes, two data bytes
// [RULE_08] B2 writes, B3 reads scratch, two bytes
// [RULE_09] B4 reads frame number, one or two bytes
// [RULE_10] B5 reads identification, two bytes
// [RULE_11] D0 reads control OUT status, one byte
// [RULE_12] Command write, then listed data transfers
// [RULE_13] Undefined codes and their data ignored
`ifndef PGCD_REGS_SVH
`define PGCD_REGS_SVH
`define PGCD_CMD_STAT_BASE 8'hD0
`define PGCD_CMD_STAT_LAST 8'hDF
`define PGCD_CMD_ERR_BASE 8'hA0
`define PGCD_CMD_ERR_LAST 8'hAF
`define PGCD_CMD_ACK_SETUP 8'hF4
`define PGCD_CMD_UNLOCK 8'hB0
`define PGCD_CMD_SCR_WR 8'hB2
`define PGCD_CMD_SCR_RD 8'hB3
`define PGCD_CMD_FRAME 8'hB4
`define PGCD_CMD_ID 8'hB5
`define PGCD_EP_MASK 8'h0F
`define PGCD_NUM_ENTRIES 16
`define PGCD_LEN_ONE 2'h1
`define PGCD_LEN_TWO 2'h2
`define PGCD_LEN_NONE 2'h0
`define PGCD_ID_VALUE 16'h5AA5
`define PGCD_UNLOCK_KEY 16'hAA37
`define PGCD_RST_WORD 16'h0000
`define PGCD_RST_BYTE 8'h00
`endif

/* File: testbench/pgcd_assertions.sv */
// Wire checks of the command port
`timescale 1ns/1ns
module pgcd_assertions (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_cmd(c);
    cmd_wr && wdata == c;
  endsequence
  sequence s_two_wr;
    data_wr ##1 data_wr ##1 !data_wr;
  endsequence
  sequence s_two_rd;
    ##[1:4] data_rd ##[1:4] data_rd;
  endsequence
  a_ack_no_data: assert property (s_cmd(8'hF4) |=> !data_wr && !data_rd)
    else $error("data strobe after setup ack");
  a_unlock_two_wr: assert property (s_cmd(8'hB0) |=> s_two_wr)
    else $error("unlock not two writes");
  a_scratch_two_wr: assert property (s_cmd(8'hB2) |=> s_two_wr)
    else $error("scratch write not two writes");
  a_status_one_rd: assert property (cmd_wr && wdata[7:4] == 4'hD |-> ##[1:4] data_rd)
    else $error("status read missing");
  a_error_one_rd: assert property (cmd_wr && wdata[7:4] == 4'hA |-> ##[1:4] data_rd)
    else $error("error code read missing");
  a_id_two_rd: assert property (s_cmd(8'hB5) |-> s_two_rd)
    else $error("id not two reads");
  a_id_low_byte: assert property (s_cmd(8'hB5) ##1 data_rd |=> rdata == 8'hA5)
    else $error("id low byte wrong");
  a_rdata_hold: assert property (!data_rd |=> $stable(rdata))
    else $error("read data moved without strobe");
endmodule : pgcd_assertions

/* File: testbench/tb_top.sv */
// Bench joining both ends of the command decoder
`timescale 1ns/1ns
`include "pgcd_regs.svh"
`define TB_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import pgcd_pkg::*;
  logic ref_clk_i = 0;
  logic rstn_i = 0;
  logic req = 0;
  logic ce = 1'b1;
  logic done, busy, ack, unl;
  logic [7:0] cmd = 8'h00;
  logic [1:0] len = 2'h0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] frame = 16'hC37E;
  logic [15:0] rd, r, scr;
  logic [7:0] st [`PGCD_NUM_ENTRIES];
  logic [7:0] er [`PGCD_NUM_ENTRIES];
  int err_count = 0;
  int comparisons = 0;
  int ack_cnt = 0;
  pgcd_if bus_if ();
  pgcd_dev pgcd_dev_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce), .bus(bus_if.dev),
    .ep_status_i(st), .ep_error_i(er), .frame_count_i(frame), .setup_ack_o(ack), .unlocked_o(unl),
    .scratch_word_o(scr));
  pgcd_host pgcd_host_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce), .bus(bus_if.host),
    .req_i(req), .req_cmd_i(cmd), .req_wdata_i(wd), .req_len_i(len), .busy_o(busy), .done_o(done),
    .rdata_o(rd));
  pgcd_assertions pgcd_assertions_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_wr(bus_if.cmd_wr),
    .data_wr(bus_if.data_wr), .data_rd(bus_if.data_rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata));
  // ----------------
  // Clock and tasks
  // ----------------
  always #25 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i) if (ack === 1'b1) ack_cnt++;
  task automatic run(input logic [7:0] c, input logic [15:0] w, input logic [1:0] n);
    int k = 0;
    cmd = c;
    wd = w;
    len = n;
    req = 1;
    @(posedge ref_clk_i);
    #2 req = 0;
    `TB_CHK("busy", 1'b1, busy)
    while (done !== 1'b1 && k < 40) begin
      @(posedge ref_clk_i);
      #2 k++;
    end
    `TB_CHK("done", 1'b1, done)
    `TB_CHK("idle", 1'b0, busy)
    r = rd;
    @(posedge ref_clk_i);
    #2;
  endtask : run
  task automatic t_ep_reads;
    for (int i = 0; i < `PGCD_NUM_ENTRIES; i++) begin
      run(8'hD0 | 8'(i), 16'h0000, 2'h1);
      `TB_CHK("status", st[i], r[7:0])
      run(8'hA0 | 8'(i), 16'h0000, 2'h1);
      `TB_CHK("error_code", er[i], r[7:0])
    end
  endtask : t_ep_reads
  task automatic t_ack;
    int a = ack_cnt;
    run(8'hF4, 16'h0000, 2'h0);
    `TB_CHK("setup_ack", a + 1, ack_cnt)
  endtask : t_ack
  task automatic t_scratch;
    run(8'hB2, 16'h9C3A, 2'h2);
    `TB_CHK("scratch_word", 16'h9C3A, scr)
    run(8'hB3, 16'h0000, 2'h2);
    `TB_CHK("scratch_read", 16'h9C3A, r)
  endtask : t_scratch
  task automatic t_unlock;
    run(8'hB0, 16'hAA37, 2'h2);
    `TB_CHK("unlocked", 1'b1, unl)
    run(8'hB0, 16'h0000, 2'h2);
    `TB_CHK("relocked", 1'b0, unl)
  endtask : t_unlock
  task automatic t_frame;
    run(8'hB4, 16'h0000, 2'h1);
    `TB_CHK("frame_low", frame[7:0], r[7:0])
    run(8'hB4, 16'h0000, 2'h2);
    `TB_CHK("frame_word", frame, r)
  endtask : t_frame
  task automatic t_id;
    run(8'hB5, 16'h0000, 2'h2);
    `TB_CHK("identification", 16'h5AA5, r)
  endtask : t_id
  task automatic t_undef;
    int a;
    run(8'hB0, 16'hAA37, 2'h2);
    a = ack_cnt;
    run(8'hC5, 16'h0000, 2'h2);
    run(8'hB1, 16'h5555, 2'h2);
    `TB_CHK("scratch_kept", 16'h9C3A, scr)
    `TB_CHK("lock_kept", 1'b1, unl)
    `TB_CHK("no_ack", a, ack_cnt)
  endtask : t_undef
  task automatic t_freeze;
    ce = 1'b0;
    cmd = 8'hB2;
    wd = 16'h1234;
    len = 2'h2;
    req = 1;
    repeat (4) @(posedge ref_clk_i);
    #2;
    `TB_CHK("frozen_busy", 1'b0, busy)
    `TB_CHK("frozen_scratch", 16'h9C3A, scr)
    req = 0;
    ce = 1'b1;
    @(posedge ref_clk_i);
    #2;
  endtask : t_freeze
  task automatic t_reset;
    rstn_i = 0;
    @(posedge ref_clk_i);
    #2 rstn_i = 1;
    `TB_CHK("reset_unlocked", 1'b0, unl)
    `TB_CHK("reset_scratch", 16'h0000, scr)
    `TB_CHK("reset_rdata", 16'h0000, rd)
    run(8'hB5, 16'h0000, 2'h2);
    `TB_CHK("id_after_reset", 16'h5AA5, r)
  endtask : t_reset
  task automatic conclude;
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // ----------------
  // Sequence
  // ----------------
  initial begin
    for (int i = 0; i < `PGCD_NUM_ENTRIES; i++) begin
      st[i] = 8'h10 + 8'(i);
      er[i] = 8'h60 + 8'(i);
    end
    repeat (16) @(posedge ref_clk_i);
    #2 rstn_i = 1;
    t_ep_reads;
    t_ack;
    t_scratch;
    t_freeze;
    t_unlock;
    t_frame;
    t_id;
    t_undef;
    t_reset;
    conclude;
  end
  initial begin
    #200000;
    err_count++;
    conclude;
  end
endmodule : tb_top
